// [rtl/cmp_ctrl.sv]
// Analog comparator control, status and interrupt logic with an APB slave
//
// Notes on behaviour
// - Enable bit powers comparator on or off
// - Disabled comparator forces output status low
// - Polarity bit selects raw or inverted result
// - Status reads one when plus exceeds minus with polarity bit clear, zero with it set
// - Hysteresis bit drives comparator hysteresis enable
// - Unimplemented control bits ignore writes, read zero
// - Output may drive shared pin when selected
// - Input pin function disconnects pull-high resistor
// - Every status change sets interrupt flag
// - Enabled raised flag requests comparator interrupt
// - Change of an enabled comparator in sleep or idle that raises a clear flag requests wake-up
// - Comparator keeps running during sleep or idle
`include "cmp_ctrl_map.svh"
`timescale 1ns/1ps
`default_nettype none

module cmp_ctrl (
  input  wire logic                       CORE_CLK_IN,
  input  wire logic                       SRST_IN,
  // APB slave
  input  wire logic                       PSEL_IN,
  input  wire logic                       PENABLE_IN,
  input  wire logic                       PWRITE_IN,
  input  wire cmp_ctrl_pkg::apb_addr_type PADDR_IN,
  input  wire cmp_ctrl_pkg::apb_data_type PWDATA_IN,
  output cmp_ctrl_pkg::apb_data_type      PRDATA_OUT,
  output logic                            PREADY_OUT,
  output logic                            PSLVERR_OUT,
  // Analog core and pins
  input  wire logic                       CMP_RESULT_IN,
  output logic                            CMP_POWER_EN_OUT,
  output logic                            CMP_HYST_EN_OUT,
  output logic                            CMP_PIN_OUT,
  output logic                            CMP_PIN_OE_OUT,
  output logic                            CMP_PULLUP_DIS_OUT,
  // Core power state and events
  input  wire logic                       CORE_SLEEP_IN,
  output logic                            WAKE_OUT,
  output logic                            IRQ_OUT
);

  // Stored control state
  logic comparator_enable_q;
  logic output_polarity_select_q;
  logic hysteresis_enable_q;
  logic irq_mask_q;
  logic pin_out_sel_q;
  logic pin_in_sel_q;
  logic comparator_enable_d;
  logic output_polarity_select_d;
  logic hysteresis_enable_d;
  logic irq_mask_d;
  logic pin_out_sel_d;
  logic pin_in_sel_d;

  // Status and event state
  logic comparator_output_status_q;
  logic comparator_output_status_d;
  logic change_flag_q;
  logic change_flag_d;
  logic wake_q;
  logic wake_d;

  // Bus read path
  cmp_ctrl_pkg::apb_data_type rdata_q;
  cmp_ctrl_pkg::apb_data_type rdata_d;

  // Synchronised comparator result
  logic result_sync;

  // Decode wires
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic hit_control;
  logic hit_irq_status;
  logic hit_irq_mask;
  logic hit_irq_set;
  logic hit_pin_func;
  logic addr_mapped;
  logic wr_control;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic wr_irq_set;
  logic wr_pin_func;

  // Event wires
  logic status_change;
  logic flag_clear;
  logic flag_sw_set;
  logic flag_rise_by_change;

  // Read image of each register
  cmp_ctrl_pkg::ctrl_byte_type control_image;
  cmp_ctrl_pkg::ctrl_byte_type irq_status_image;
  cmp_ctrl_pkg::ctrl_byte_type irq_mask_image;
  cmp_ctrl_pkg::ctrl_byte_type pin_func_image;

  // Bring the asynchronous analog result into the clock domain
  cmp_sync #(
    .STAGES   (`CMP_SYNC_STAGES)
  ) u_result_sync (
    .clk_in   (CORE_CLK_IN),
    .srst_in  (SRST_IN),
    .async_in (CMP_RESULT_IN),
    .sync_out (result_sync)
  );

  // APB phase and address decode
  assign setup_phase    = PSEL_IN & ~PENABLE_IN;
  assign access_phase   = PSEL_IN & PENABLE_IN;
  assign wr_access      = access_phase & PWRITE_IN;
  assign hit_control    = (PADDR_IN == `CMP_CONTROL_OFS);
  assign hit_irq_status = (PADDR_IN == `CMP_IRQ_STATUS_OFS);
  assign hit_irq_mask   = (PADDR_IN == `CMP_IRQ_MASK_OFS);
  assign hit_irq_set    = (PADDR_IN == `CMP_IRQ_SET_OFS);
  assign hit_pin_func   = (PADDR_IN == `CMP_PIN_FUNC_OFS);
  assign addr_mapped    = hit_control | hit_irq_status | hit_irq_mask
                        | hit_irq_set | hit_pin_func;

  // Write strobes, one per register
  assign wr_control    = wr_access & hit_control;
  assign wr_irq_status = wr_access & hit_irq_status;
  assign wr_irq_mask   = wr_access & hit_irq_mask;
  assign wr_irq_set    = wr_access & hit_irq_set;
  assign wr_pin_func   = wr_access & hit_pin_func;

  // Zero wait states; error only for unmapped addresses
  assign PREADY_OUT  = 1'h1;
  assign PSLVERR_OUT = access_phase & ~addr_mapped;

  // Next control values; only bits 6, 5 and 0 hold state
  assign comparator_enable_d      = wr_control ? PWDATA_IN[`CMP_EN_BIT] : comparator_enable_q;
  assign output_polarity_select_d = wr_control ? PWDATA_IN[`CMP_POL_BIT] : output_polarity_select_q;
  assign hysteresis_enable_d      = wr_control ? PWDATA_IN[`CMP_HYST_BIT] : hysteresis_enable_q;

  // Next mask and pin function values
  assign irq_mask_d    = wr_irq_mask ? PWDATA_IN[`CMP_IRQ_CHANGE_BIT] : irq_mask_q;
  assign pin_out_sel_d = wr_pin_func ? PWDATA_IN[`CMP_PIN_OUT_BIT] : pin_out_sel_q;
  assign pin_in_sel_d  = wr_pin_func ? PWDATA_IN[`CMP_PIN_IN_BIT] : pin_in_sel_q;

  // Comparator enable; low at reset keeps the core unpowered
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      comparator_enable_q <= `CMP_EN_RST;
    end else begin
      comparator_enable_q <= comparator_enable_d;
    end
  end

  // Output polarity select
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      output_polarity_select_q <= `CMP_POL_RST;
    end else begin
      output_polarity_select_q <= output_polarity_select_d;
    end
  end

  // Hysteresis enable; on at reset
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      hysteresis_enable_q <= `CMP_HYST_RST;
    end else begin
      hysteresis_enable_q <= hysteresis_enable_d;
    end
  end

  // Interrupt mask
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      irq_mask_q <= `CMP_MASK_RST;
    end else begin
      irq_mask_q <= irq_mask_d;
    end
  end

  // Output pin drive selection
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      pin_out_sel_q <= `CMP_PIN_OUT_RST;
    end else begin
      pin_out_sel_q <= pin_out_sel_d;
    end
  end

  // Input pin function selection
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      pin_in_sel_q <= `CMP_PIN_IN_RST;
    end else begin
      pin_in_sel_q <= pin_in_sel_d;
    end
  end

  // Output status: polarity applied, forced low while disabled
  assign comparator_output_status_d = comparator_enable_q
                                    & (result_sync ^ output_polarity_select_q);

  // Status follows the comparator regardless of core sleep
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      comparator_output_status_q <= 1'h0;
    end else begin
      comparator_output_status_q <= comparator_output_status_d;
    end
  end

  // Change on either edge of the status bit
  assign status_change = comparator_output_status_d ^ comparator_output_status_q;

  // Software clear by writing one, software preset through the set register
  assign flag_clear  = wr_irq_status & PWDATA_IN[`CMP_IRQ_CHANGE_BIT];
  assign flag_sw_set = wr_irq_set & PWDATA_IN[`CMP_IRQ_CHANGE_BIT];

  // Hardware set wins over a clear in the same cycle
  assign change_flag_d = status_change | flag_sw_set
                       | (change_flag_q & ~flag_clear);

  // A change wakes the core only when it raises a clear flag
  assign flag_rise_by_change = status_change & ~change_flag_q;

  // Wake request held until the core leaves sleep or idle
  assign wake_d = CORE_SLEEP_IN
                & ((flag_rise_by_change & comparator_enable_q) | wake_q);

  // Interrupt flag, sticky until written with a one
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      change_flag_q <= 1'h0;
    end else begin
      change_flag_q <= change_flag_d;
    end
  end

  // Wake-up request state
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      wake_q <= 1'h0;
    end else begin
      wake_q <= wake_d;
    end
  end

  // Register read images, unimplemented bits tied to zero
  assign control_image = {1'h0,
                          comparator_enable_q,
                          output_polarity_select_q,
                          comparator_output_status_q,
                          3'h0,
                          hysteresis_enable_q};
  assign irq_status_image = {7'h00, change_flag_q};
  assign irq_mask_image   = {7'h00, irq_mask_q};
  assign pin_func_image   = {6'h00, pin_in_sel_q, pin_out_sel_q};

  // Read mux; the set register and unmapped space read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_control) begin
      rdata_d = {24'h00_0000, control_image};
    end else if (hit_irq_status) begin
      rdata_d = {24'h00_0000, irq_status_image};
    end else if (hit_irq_mask) begin
      rdata_d = {24'h00_0000, irq_mask_image};
    end else if (hit_pin_func) begin
      rdata_d = {24'h00_0000, pin_func_image};
    end
  end

  // Read data captured in the setup cycle, held through the access cycle
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup_phase) begin
      rdata_q <= (PWRITE_IN) ? 32'h0000_0000 : rdata_d;
    end
  end

  assign PRDATA_OUT = rdata_q;

  // Analog control outputs
  assign CMP_POWER_EN_OUT = comparator_enable_q;
  assign CMP_HYST_EN_OUT  = hysteresis_enable_q;

  // Shared pins: output drive and pull-high release
  assign CMP_PIN_OUT        = comparator_output_status_q;
  assign CMP_PIN_OE_OUT     = pin_out_sel_q;
  assign CMP_PULLUP_DIS_OUT = pin_in_sel_q;

  // Level interrupt and wake-up requests
  assign IRQ_OUT  = change_flag_q & irq_mask_q;
  assign WAKE_OUT = wake_q;

endmodule

`default_nettype wire

// [rtl/cmp_ctrl_map.svh]
// Register offsets, field positions and reset values of the comparator control block
`ifndef CMP_CTRL_MAP_SVH
`define CMP_CTRL_MAP_SVH

// Byte offsets on the APB bus
`define CMP_CONTROL_OFS     8'h00
`define CMP_IRQ_STATUS_OFS  8'h04
`define CMP_IRQ_MASK_OFS    8'h08
`define CMP_IRQ_SET_OFS     8'h0c
`define CMP_PIN_FUNC_OFS    8'h10

// comparator_control fields
`define CMP_EN_BIT          6
`define CMP_POL_BIT         5
`define CMP_OUT_BIT         4
`define CMP_HYST_BIT        0

// Interrupt status, mask and set registers
`define CMP_IRQ_CHANGE_BIT  0

// Pin function register fields
`define CMP_PIN_OUT_BIT     0
`define CMP_PIN_IN_BIT      1

// Reset values
`define CMP_EN_RST          1'h0
`define CMP_POL_RST         1'h0
`define CMP_HYST_RST        1'h1
`define CMP_MASK_RST        1'h0
`define CMP_PIN_OUT_RST     1'h0
`define CMP_PIN_IN_RST      1'h0

// Synchroniser depth for the analog result
`define CMP_SYNC_STAGES     2

`endif

// [rtl/cmp_ctrl_pkg.sv]
// Types shared by the comparator control block
package cmp_ctrl_pkg;

  typedef logic [7:0]  apb_addr_type;
  typedef logic [31:0] apb_data_type;
  typedef logic [7:0]  ctrl_byte_type;

endpackage

// [rtl/cmp_sync.sv]
// Multi-stage level synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module cmp_sync #(
  parameter int STAGES = 2
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic [STAGES-1:0] chain_q;

  // Shift chain; only the last stage is read outside
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain_q[STAGES-1];

endmodule

`default_nettype wire

// [sim/analog_pair.sv]
// Analog input pair model feeding the comparator core
`timescale 1ns/1ps
`default_nettype none

module analog_pair (
  output var logic result_out
);
  initial result_out = 1'b0;

  // Settles the compare off the clock grid, as a real comparator does
  task automatic drive(input int plus_mv, input int minus_mv);
    #1.3;
    result_out = plus_mv > minus_mv;
  endtask
endmodule

`default_nettype wire

// [sim/cmp_ctrl_properties.sv]
// Port-level checks of the comparator control block
`timescale 1ns/1ps
`default_nettype none

module cmp_ctrl_checker (
  input wire logic                       CORE_CLK_IN,
  input wire logic                       SRST_IN,
  input wire logic                       PSEL_IN,
  input wire logic                       PENABLE_IN,
  input wire logic                       PWRITE_IN,
  input wire cmp_ctrl_pkg::apb_addr_type PADDR_IN,
  input wire cmp_ctrl_pkg::apb_data_type PWDATA_IN,
  input wire logic                       PREADY_OUT,
  input wire logic                       CMP_RESULT_IN,
  input wire logic                       CMP_POWER_EN_OUT,
  input wire logic                       CMP_HYST_EN_OUT,
  input wire logic                       CMP_PIN_OUT,
  input wire logic                       CMP_PIN_OE_OUT,
  input wire logic                       CMP_PULLUP_DIS_OUT,
  input wire logic                       CORE_SLEEP_IN,
  input wire logic                       WAKE_OUT,
  input wire logic                       IRQ_OUT
);
  // Completed writes to the control, pin function and mask registers
  wire  wr      = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
  wire  wr_ctrl = wr && PADDR_IN == 8'h00;
  wire  wr_pin  = wr && PADDR_IN == 8'h10;
  wire  wr_mask = wr && PADDR_IN == 8'h08;
  wire  en_wr   = wr_ctrl && PWDATA_IN[6];
  logic mask_q;

  // Shadow of the interrupt mask
  always_ff @(posedge CORE_CLK_IN)
    mask_q <= SRST_IN ? 1'b0 : (wr_mask ? PWDATA_IN[0] : mask_q);

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);

  power_on_a: assert property ($rose(CMP_POWER_EN_OUT) |-> $past(en_wr))
    else $error("power rose without write");
  off_low_a: assert property (!CMP_POWER_EN_OUT && !$past(CMP_POWER_EN_OUT) |-> !CMP_PIN_OUT)
    else $error("status high while off");
  hyst_ctrl_a: assert property (wr_ctrl |=> CMP_HYST_EN_OUT == $past(PWDATA_IN[0]))
    else $error("hysteresis not written");
  pin_func_a: assert property (wr_pin |=> CMP_PIN_OE_OUT == $past(PWDATA_IN[0])
    && CMP_PULLUP_DIS_OUT == $past(PWDATA_IN[1]))
    else $error("pin function not written");
  sync_delay_a: assert property ($changed(CMP_PIN_OUT) |->
    $past(CMP_RESULT_IN, 3) != $past(CMP_RESULT_IN, 4) || $past(wr_ctrl) || $past(wr_ctrl, 2))
    else $error("status change without cause");
  change_irq_a: assert property ($changed(CMP_PIN_OUT) && mask_q |-> IRQ_OUT)
    else $error("change raised no interrupt");
  mask_off_a: assert property (wr_mask && !PWDATA_IN[0] |=> !IRQ_OUT)
    else $error("masked interrupt high");
  wake_cause_a: assert property ($rose(WAKE_OUT) |-> $changed(CMP_PIN_OUT) && $past(CORE_SLEEP_IN))
    else $error("wake without change in sleep");
  wake_hold_a: assert property (WAKE_OUT && CORE_SLEEP_IN |=> WAKE_OUT)
    else $error("wake dropped in sleep");

  // Main scenarios reached
  cover property ($rose(WAKE_OUT));
  cover property ($rose(IRQ_OUT));
  cover property ($fell(CMP_PIN_OUT) && CMP_POWER_EN_OUT);
endmodule

bind cmp_ctrl cmp_ctrl_checker chk (.CORE_CLK_IN(CORE_CLK_IN), .SRST_IN(SRST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PREADY_OUT(PREADY_OUT), .CMP_RESULT_IN(CMP_RESULT_IN), .CMP_POWER_EN_OUT(CMP_POWER_EN_OUT),
  .CMP_HYST_EN_OUT(CMP_HYST_EN_OUT), .CMP_PIN_OUT(CMP_PIN_OUT), .CMP_PIN_OE_OUT(CMP_PIN_OE_OUT),
  .CMP_PULLUP_DIS_OUT(CMP_PULLUP_DIS_OUT), .CORE_SLEEP_IN(CORE_SLEEP_IN), .WAKE_OUT(WAKE_OUT), .IRQ_OUT(IRQ_OUT));

`default_nettype wire

// [sim/cmp_ctrl_tb.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none

module cmp_ctrl_tb;
  logic                       clk, rst, psel, pen, pwr, slp, res, rdy, irq, wake;
  logic                       pwr_en, hst, oe, pud, pol, h, r, prev_r, pin, err, se;
  logic [7:0]                 pa;
  logic [31:0]                pwd;
  cmp_ctrl_pkg::apb_data_type prd, ex;
  cmp_ctrl_pkg::apb_data_type exq[$];
  int                         error_cnt, tests_run, pl, mn;

  cmp_ctrl dut (.CORE_CLK_IN(clk), .SRST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
    .CMP_RESULT_IN(res), .CMP_POWER_EN_OUT(pwr_en), .CMP_HYST_EN_OUT(hst), .CMP_PIN_OUT(pin),
    .CMP_PIN_OE_OUT(oe), .CMP_PULLUP_DIS_OUT(pud), .CORE_SLEEP_IN(slp), .WAKE_OUT(wake), .IRQ_OUT(irq));
  analog_pair an (.result_out(res));

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Read with its expected word noted first
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic chk(input string n, input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic results;
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Read data monitor against the oldest note
  always @(posedge clk) begin
    // Error response expected only outside the mapped words
    if (psel && pen && rdy === 1'b1) begin
      se = !(pa inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10});
      tests_run++;
      if (err !== se) begin
        error_cnt++;
        $display("Error pslverr exp %b got %b", se, err);
      end
    end
    if (psel && pen && !pwr && rdy === 1'b1) begin
      ex = exq.pop_front();
      tests_run++;
      if (prd !== ex) begin
        error_cnt++;
        $display("Error prdata exp %h got %h", ex, prd);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Watchdog
  initial begin
    #20000;
    error_cnt++;
    results();
  end

  initial begin
    rst = 1'b1;
    {psel, pen, pwr, slp, pa, pwd, prev_r} = '0;
    void'($urandom(58994));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h01);
    rd(8'h14, 32'h00);
    apb(1'b1, 8'h00, 32'hff);
    repeat (4) @(posedge clk);
    rd(8'h00, 32'h71);
    rd(8'h04, 32'h01);
    apb(1'b1, 8'h08, 32'h01);
    // Random polarity, hysteresis and input levels
    for (int i = 0; i < 8; i++) begin
      pol = 1'($urandom % 2);
      h = 1'($urandom % 2);
      pl = $urandom % 1000;
      mn = $urandom % 1000;
      r = pl > mn;
      apb(1'b1, 8'h00, {25'h0, 1'b1, pol, 4'h0, h});
      repeat (5) @(posedge clk);
      apb(1'b1, 8'h04, 32'h01);
      an.drive(pl, mn);
      repeat (6) @(posedge clk);
      chk("hyst", hst, h);
      chk("power", pwr_en, 1'b1);
      chk("pin", pin, r ^ pol);
      rd(8'h00, {25'h0, 1'b1, pol, r ^ pol, 3'h0, h});
      rd(8'h04, {31'h0, r != prev_r});
      chk("irq", irq, r != prev_r);
      prev_r = r;
    end
    apb(1'b1, 8'h00, 32'h20);
    repeat (4) @(posedge clk);
    rd(8'h00, 32'h20);
    chk("power", pwr_en, 1'b0);
    chk("pin", pin, 1'b0);
    // Wake in sleep, then blocked by a preset flag
    apb(1'b1, 8'h00, 32'h40);
    apb(1'b1, 8'h08, 32'h00);
    slp <= 1'b1;
    apb(1'b1, 8'h04, 32'h01);
    an.drive(!prev_r, 0);
    repeat (6) @(posedge clk);
    chk("wake", wake, 1'b1);
    chk("irq", irq, 1'b0);
    rd(8'h04, 32'h01);
    slp <= 1'b0;
    repeat (2) @(posedge clk);
    chk("wake", wake, 1'b0);
    apb(1'b1, 8'h04, 32'h01);
    apb(1'b1, 8'h0c, 32'h01);
    rd(8'h04, 32'h01);
    slp <= 1'b1;
    an.drive(prev_r, 0);
    repeat (6) @(posedge clk);
    chk("wake", wake, 1'b0);
    slp <= 1'b0;
    // Disabled before sleep: no status change, no flag, no wake
    apb(1'b1, 8'h00, 32'h00);
    repeat (4) @(posedge clk);
    apb(1'b1, 8'h04, 32'h01);
    slp <= 1'b1;
    an.drive(!prev_r, 0);
    repeat (6) @(posedge clk);
    chk("wake", wake, 1'b0);
    rd(8'h04, 32'h00);
    slp <= 1'b0;
    apb(1'b1, 8'h10, 32'h03);
    @(posedge clk);
    chk("pin_oe", oe, 1'b1);
    chk("pullup_dis", pud, 1'b1);
    rd(8'h10, 32'h03);
    apb(1'b1, 8'h14, 32'hff);
    rd(8'h14, 32'h00);
    results();
  end
endmodule

`default_nettype wire
